/* File: ebac_ctrl.sv */
// Functional notes
// - mode 11 ends access on ack or programmed count, either.
// - mode 00 ack only, 01 count only, 10 count and ack.
// - either mode ends at first high ack or count expiry.
// - multiprocessor space accesses complete on ack alone.
// - auto wait bit adds one wait state to mp space accesses.
// - auto wait enable sits at bit 29 of wait configuration.
// - as slave, drive ack low in first access cycle.
// - master with auto wait ignores ack in first mp cycle.
// - all processors share the same auto wait bit value.
// - suspend floats address, data, selects and strobes next cycle.
// - suspend during access aborts it, restarts after release.
// - suspend while idle stalls next access until after release.
// - release re-drives strobes after address, clears wait counter.
// - external accesses only while holding bus mastership; checked only on leaving idle, not on restart after suspend.
// - read drives address and bank select, held across same bank.
// - read strobe held through waits, data captured, then negated.
// - failed conditional read: address and select only.
// - write strobe and data through waits, then data released.
// - failed conditional write: address, select and early write pin only.
// - next access address and select presented next cycle.
//
// external bus master for banked asynchronous memory
// assumes core request held until req_done and inputs synchronous to clk
`timescale 1ns/1ps
`include "ebac_defs.svh"
module ebac_ctrl
  import ebac_pkg::*;
(
  input  wire logic                    clk,          // 25 MHz clock
  input  wire logic                    rst_n,        // async reset, low
  input  wire logic [3:0]              reg_addr,     // register offset
  input  wire logic [31:0]             reg_wdata,    // register write data
  input  wire logic                    reg_wr,       // write strobe
  input  wire logic                    reg_rd,       // read strobe
  output logic      [31:0]             reg_rdata,    // read data, next cycle
  input  wire ebac_req_t               req,          // core access request
  output logic                         req_done,     // access finished pulse
  output logic      [`EBAC_DATA_W-1:0] rdata,        // captured read data
  input  wire logic                    bus_master,   // holds bus mastership
  input  wire logic                    bus_suspend_n,// suspend request
  input  wire logic                    ack_in,       // acknowledge input
  input  wire logic [1:0]              dma_req,      // dma grant requests
  input  wire logic                    boot_access,  // boot space select
  input  wire logic [`EBAC_DATA_W-1:0] data_i,       // data pins in
  input  wire logic                    slave_hit,    // mp slave access seen
  output logic      [`EBAC_ADDR_W-1:0] addr_o,       // address pins
  output logic                         addr_oe,      // address/ctrl enable
  output logic      [`EBAC_DATA_W-1:0] data_o,       // data pins out
  output logic                         data_oe,      // data pins enable
  output logic      [3:0]              bank_select_n,// bank selects
  output logic                         rd_n,         // read strobe
  output logic                         wr_n,         // write strobe
  output logic                         early_write_indicator_n, // early wr
  output logic                         boot_select_n,// boot select
  output logic      [1:0]              dma_grant_n,  // dma grants
  output logic                         ack_o,        // slave ack out
  output logic                         ack_oe        // slave ack enable
);

  typedef struct packed {
    ebac_state_t             fsm;
    logic [31:0]             wait_cfg;
    logic                    susp;
    logic                    busy;
    logic                    started;
    ebac_pins_t              pins;
    logic [1:0]              last_bank;
    logic                    sel_held;
    logic [1:0]              grant_mem;
    logic                    done;
    logic [`EBAC_DATA_W-1:0] rdata;
    logic [31:0]             rd_data;
    logic                    slave_first;
    logic                    ack_o;
    logic                    ack_oe;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  logic [1:0] cur_mode;
  logic [2:0] cur_count;
  logic       wg_start;
  logic       wg_clear;
  logic       wg_run;
  logic       wg_done;
  logic       can_go;

  // bank fields picked by index
  assign cur_mode  = st.wait_cfg[`EBAC_WM_LSB(req.bank) +: 2];
  assign cur_count = st.wait_cfg[`EBAC_WS_LSB(req.bank) +: 3];

  ebac_wait_gen u_wait (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (wg_start),
    .clear    (wg_clear),
    .running  (wg_run),
    .mode     (cur_mode),
    .count    (cur_count),
    .mp_space (req.mp_space),
    .mp_wait  (st.wait_cfg[`EBAC_MP_WAIT_BIT]),
    .ack      (ack_in),
    .done     (wg_done)
  );

  always_comb begin
    next_st  = st;
    next_st.done = 1'b0;
    next_st.susp = !bus_suspend_n;
    // master only
    // done request still stands for one cycle; never start it twice
    can_go   = req.valid && bus_master && !st.susp && !st.done;
    wg_run   = (st.fsm == EBAC_ACCESS) && !st.susp;
    wg_clear = st.susp;
    wg_start = 1'b0;

    if (reg_wr && reg_addr == `EBAC_REG_WAIT)
      next_st.wait_cfg = reg_wdata;

    case (st.fsm)
      EBAC_IDLE: begin
        if (req.valid && bus_master && st.susp && !st.done) begin
          next_st.fsm = EBAC_HALT;
        end else if (can_go) begin
          wg_start    = 1'b1;
          next_st.fsm = EBAC_ACCESS;
        end
      end
      EBAC_ACCESS: begin
        if (st.susp) begin
          next_st.fsm = EBAC_HALT;
        end else if (wg_done) begin
          next_st.done = 1'b1;
          if (!req.write && req.cond_ok)
            next_st.rdata = data_i;
          next_st.fsm = EBAC_IDLE;
        end
      end
      EBAC_HALT: begin
        if (!st.susp) begin
          wg_start    = 1'b1;
          next_st.fsm = EBAC_ACCESS;
        end
      end
      default: next_st.fsm = EBAC_IDLE;
    endcase

    next_st.busy = (next_st.fsm != EBAC_IDLE);

    // pin image for the coming cycle
    next_st.pins.rd_n = 1'b1;
    next_st.pins.wr_n = 1'b1;
    next_st.pins.data_oe = 1'b0;
    next_st.pins.early_write_indicator_n = 1'b1;
    next_st.pins.boot_select_n = 1'b1;
    next_st.grant_mem = dma_req;
    if (next_st.fsm == EBAC_ACCESS) begin
      next_st.pins.addr = req.addr;
      next_st.pins.early_write_indicator_n = !req.write;
      next_st.last_bank = req.bank;
      next_st.sel_held  = 1'b1;
      if (boot_access) begin
        next_st.pins.boot_select_n = 1'b0;
        next_st.sel_held = 1'b0;
      end
      if (req.cond_ok) begin
        next_st.pins.rd_n = req.write;
        next_st.pins.wr_n = !req.write;
        next_st.pins.data_oe = req.write;
        next_st.pins.data_o = req.wdata;
      end
    end
    next_st.pins.bank_select_n = 4'hF;
    if (next_st.sel_held && next_st.fsm != EBAC_HALT)
      next_st.pins.bank_select_n[next_st.last_bank] = 1'b0;
    next_st.pins.dma_grant_n = ~next_st.grant_mem;
    next_st.pins.addr_oe = !next_st.susp;
    if (next_st.susp)
      next_st.pins.data_oe = 1'b0;

    // slave holds ack low first cycle
    // remembers the hit so ack stays high after the first cycle
    next_st.slave_first = slave_hit;
    next_st.ack_oe = slave_hit;
    next_st.ack_o  = !(slave_hit && !st.slave_first);

    next_st.rd_data = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `EBAC_REG_WAIT:   next_st.rd_data = st.wait_cfg;
        `EBAC_REG_STATUS: begin
          next_st.rd_data[`EBAC_ST_BUSY]   = st.busy;
          next_st.rd_data[`EBAC_ST_SUSP]   = st.susp;
          next_st.rd_data[`EBAC_ST_MASTER] = bus_master;
        end
        `EBAC_REG_CAPT:   next_st.rd_data = st.rdata;
        default:          next_st.rd_data = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.fsm      <= EBAC_IDLE;
      st.wait_cfg <= `EBAC_WAIT_RESET;
      st.pins.rd_n <= 1'b1;
      st.pins.wr_n <= 1'b1;
      st.pins.early_write_indicator_n <= 1'b1;
      st.pins.boot_select_n <= 1'b1;
      st.pins.bank_select_n <= 4'hF;
      st.pins.dma_grant_n   <= 2'h3;
      st.ack_o    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign reg_rdata = st.rd_data;
  assign req_done  = st.done;
  assign rdata     = st.rdata;
  assign addr_o    = st.pins.addr;
  assign addr_oe   = st.pins.addr_oe;
  assign data_o    = st.pins.data_o;
  assign data_oe   = st.pins.data_oe;
  assign bank_select_n = st.pins.bank_select_n;
  assign rd_n      = st.pins.rd_n;
  assign wr_n      = st.pins.wr_n;
  assign early_write_indicator_n = st.pins.early_write_indicator_n;
  assign boot_select_n = st.pins.boot_select_n;
  assign dma_grant_n   = st.pins.dma_grant_n;
  assign ack_o     = st.ack_o;
  assign ack_oe    = st.ack_oe;

endmodule : ebac_ctrl

/* File: ebac_defs.svh */
// constants for the external bus access control block
// assumes a 25 MHz clk and a single-word bus per access
`ifndef EBAC_DEFS_SVH
`define EBAC_DEFS_SVH

`define EBAC_ADDR_W         24
`define EBAC_DATA_W         32
`define EBAC_BANKS          4
// wait configuration word layout
`define EBAC_WM_LSB(b)      ((b) * 5)
`define EBAC_WS_LSB(b)      ((b) * 5 + 2)
`define EBAC_MP_WAIT_BIT    29
`define EBAC_WAIT_RESET     32'h21AD_6B5A
// wait mode encodings
`define EBAC_WM_ACK         2'h0
`define EBAC_WM_INT         2'h1
`define EBAC_WM_BOTH        2'h2
`define EBAC_WM_EITHER      2'h3
// register port offsets
`define EBAC_REG_WAIT       4'h0
`define EBAC_REG_STATUS     4'h4
`define EBAC_REG_CAPT       4'h8
// status word field positions
`define EBAC_ST_BUSY        0
`define EBAC_ST_SUSP        1
`define EBAC_ST_MASTER      2

`endif

/* File: ebac_pkg.sv */
// types shared by the external bus access control block
// assumes ebac_defs.svh is on the include path
`include "ebac_defs.svh"
package ebac_pkg;

  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic                    cond_ok;
    logic                    mp_space;
    logic [1:0]              bank;
    logic [`EBAC_ADDR_W-1:0] addr;
    logic [`EBAC_DATA_W-1:0] wdata;
  } ebac_req_t;

  typedef struct packed {
    logic [`EBAC_ADDR_W-1:0] addr;
    logic [`EBAC_DATA_W-1:0] data_o;
    logic                    data_oe;
    logic                    addr_oe;
    logic [3:0]              bank_select_n;
    logic                    rd_n;
    logic                    wr_n;
    logic                    early_write_indicator_n;
    logic                    boot_select_n;
    logic [1:0]              dma_grant_n;
  } ebac_pins_t;

  typedef enum logic [1:0] {
    EBAC_IDLE,
    EBAC_ACCESS,
    EBAC_HALT
  } ebac_state_t;

endpackage : ebac_pkg

/* File: ebac_wait_gen.sv */
// wait count and completion decision for one external access
// assumes mode and count are stable while an access is running
`timescale 1ns/1ps
module ebac_wait_gen
  import ebac_pkg::*;
(
  input  wire logic       clk,       // bus clock
  input  wire logic       rst_n,     // async reset, active low
  input  wire logic       start,     // access begins next cycle
  input  wire logic       clear,     // held while suspended, aborts the count
  input  wire logic       running,   // access cycle in progress
  input  wire logic [1:0] mode,      // bank wait mode
  input  wire logic [2:0] count,     // programmed wait states
  input  wire logic       mp_space,  // multiprocessor space access
  input  wire logic       mp_wait,   // auto wait enable
  input  wire logic       ack,       // sampled acknowledge
  output logic            done       // access finishes this cycle
);

  typedef struct packed {
    logic [2:0] waited;
  } wg_state_t;

  wg_state_t st;
  wg_state_t next_st;
  logic      expired;
  logic      first;

  always_comb begin
    next_st = st;
    // 111 encodes zero wait states, count expired at once
    expired = (count == 3'h7) || (st.waited >= count);
    first   = (st.waited == 3'h0);
    if (!running) begin
      done = 1'b0;
    end else if (mp_space) begin
      done = ack && !(mp_wait && first);
    end else begin
      case (mode)
        `EBAC_WM_ACK:  done = ack;
        `EBAC_WM_INT:  done = expired;
        `EBAC_WM_BOTH: done = expired && ack;
        `EBAC_WM_EITHER: done = expired || ack;
        default: done = ack;
      endcase
    end
    if (clear || start)
      next_st.waited = 3'h0;
    else if (running && !done && st.waited != 3'h7)
      next_st.waited = st.waited + 3'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

endmodule : ebac_wait_gen

/* File: ebac_checker.sv */
// pin-level assertions for ebac_ctrl
// assumes one clk domain, rst_n asynchronous and active low
`timescale 1ns/1ps
`include "ebac_defs.svh"
module ebac_checker
  import ebac_pkg::*;
(
  input wire logic                    clk,           // bus clock
  input wire logic                    rst_n,         // async reset, low
  input wire ebac_req_t               req,           // core request
  input wire logic                    req_done,      // completion pulse
  input wire logic                    bus_master,    // mastership held
  input wire logic                    bus_suspend_n, // suspend input
  input wire logic                    slave_hit,     // slave access seen
  input wire logic [`EBAC_ADDR_W-1:0] addr_o,        // address pins
  input wire logic                    addr_oe,       // pin enable
  input wire logic                    data_oe,       // data enable
  input wire logic [3:0]              bank_select_n, // bank selects
  input wire logic                    rd_n,          // read strobe
  input wire logic                    wr_n,          // write strobe
  input wire logic                    early_write_indicator_n, // early write pin
  input wire logic                    ack_o,         // slave ack out
  input wire logic                    ack_oe         // slave ack enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_float_next: assert property (!bus_suspend_n |-> ##[1:2] !addr_oe)
    else $error("pins still driven after suspend");
  a_abort_held: assert property (!bus_suspend_n [*3] |-> !req_done)
    else $error("access finished under suspend");
  a_master_only: assert property (rd_n && wr_n && !bus_master |=> rd_n && wr_n)
    else $error("access started without mastership");
  a_cond_quiet: assert property (req.valid && !req.cond_ok |-> rd_n && wr_n)
    else $error("strobe on a failed conditional access");
  a_write_drive: assert property (!wr_n |-> data_oe && addr_oe)
    else $error("write strobe without data driven");
  a_early_write: assert property (!wr_n |-> !early_write_indicator_n)
    else $error("early write pin high during write");
  a_read_off: assert property (!rd_n |-> !data_oe)
    else $error("data driven during read");
  a_read_bank: assert property (!rd_n |-> bank_select_n == ~(4'h1 << req.bank) && addr_o == req.addr)
    else $error("read address or bank select wrong");
  a_strobe_end: assert property ($rose(rd_n) && addr_oe && bus_suspend_n && $past(bus_suspend_n) |-> req_done)
    else $error("read strobe dropped before completion");
  a_slave_ack: assert property ($rose(slave_hit) |-> ##[1:2] (ack_oe && !ack_o))
    else $error("slave ack not low in first cycle");
endmodule : ebac_checker

bind ebac_ctrl ebac_checker i_ebac_checker (.clk, .rst_n, .req, .req_done, .bus_master,
  .bus_suspend_n, .slave_hit, .addr_o, .addr_oe, .data_oe, .bank_select_n, .rd_n, .wr_n,
  .early_write_indicator_n, .ack_o, .ack_oe);

/* File: ebac_mem_model.sv */
// far-side asynchronous memory whose acknowledge rises after a set delay
// assumes strobes count only while addr_oe drives them
`timescale 1ns/1ps
`include "ebac_defs.svh"
module ebac_mem_model (
  input  wire logic                    clk,     // bus clock
  input  wire logic [`EBAC_ADDR_W-1:0] addr_o,  // address pins
  input  wire logic                    addr_oe, // pins driven
  input  wire logic                    rd_n,    // read strobe
  input  wire logic                    wr_n,    // write strobe
  input  wire logic [`EBAC_DATA_W-1:0] data_o,  // write data
  input  wire logic [2:0]              ack_dly, // strobe cycles before ack
  output logic                         ack_in,  // acknowledge
  output logic      [`EBAC_DATA_W-1:0] data_i   // read data
);
  logic [`EBAC_DATA_W-1:0] mem [16];
  logic [`EBAC_DATA_W-1:0] last = '0;
  logic [2:0]              cnt  = '0;
  logic                    act;
  assign act = addr_oe && !(rd_n && wr_n);
  // ack pulled low while no strobe is driven with addr_oe
  assign ack_in = act && cnt >= ack_dly;
  // released lines toggle so a stale word never reads as good
  assign data_i = (addr_oe && !rd_n) ? mem[addr_o[3:0]] : ~last;
  always @(posedge clk) begin
    last <= data_i;
    cnt  <= act ? cnt + {2'h0, cnt != 3'h7} : 3'h0;
    if (addr_oe && !wr_n)
      mem[addr_o[3:0]] <= data_o;
  end
endmodule : ebac_mem_model

/* File: tb_top.sv */
// self-checking bench: table of accesses, then suspend and mastership cases
// assumes ebac_mem_model on the pins and ebac_checker bound to the design
`timescale 1ns/1ps
`include "ebac_defs.svh"
module tb_top;
  import ebac_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, bus_master, bus_suspend_n, slave_hit, ack_in;
  logic req_done, addr_oe, data_oe, rd_n, wr_n, ewi_n, boot_n, ack_o, ack_oe;
  logic [3:0]  reg_addr, bank_select_n;
  logic [31:0] reg_wdata, reg_rdata, rdata, data_i, data_o, er, v, cfg;
  logic [1:0]  dma_req, dma_grant_n;
  logic [2:0]  ack_dly;
  logic [23:0] addr_o;
  logic [31:0] em [16];
  ebac_req_t   req, r;
  int          n_errors, num_checks, n;
  // wr ok mp bank addr ackdelay waits(-1 unchecked); bank b uses mode b, three waits
  int rt[13][7] = '{'{1,1,0,0,1,1,1}, '{0,1,0,0,1,4,4}, '{1,1,0,1,2,0,3},
    '{0,1,0,1,2,5,3}, '{1,1,0,2,3,1,3}, '{0,1,0,2,3,5,5}, '{1,1,0,3,4,1,1},
    '{0,1,0,3,4,5,3}, '{1,1,1,1,5,0,1}, '{0,1,1,1,5,2,2}, '{0,0,0,1,1,0,-1},
    '{1,0,0,1,2,0,-1}, '{0,1,0,1,2,0,3}};

  ebac_ctrl i_ebac_ctrl (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .req, .req_done, .rdata, .bus_master, .bus_suspend_n, .ack_in, .dma_req,
    .boot_access(1'b0), .data_i, .slave_hit, .addr_o, .addr_oe, .data_o, .data_oe,
    .bank_select_n, .rd_n, .wr_n, .early_write_indicator_n(ewi_n), .boot_select_n(boot_n),
    .dma_grant_n, .ack_o, .ack_oe);
  ebac_mem_model i_ebac_mem_model (.clk, .addr_o, .addr_oe, .rd_n, .wr_n, .data_o, .ack_dly,
    .ack_in, .data_i);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wreg

  task rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rreg

  // s above zero holds suspend for three cycles from cycle s of the access
  task wt(input int s, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (s > 0) bus_suspend_n <= !(k >= s && k < s + 3);
      #1;
    end while (req_done !== 1'b1 && k < 60);
    if (k >= 60) begin
      chk("req_done", 1, 0);
      close_out();
    end
  endtask : wt

  function automatic ebac_req_t mk(int w, int ok, int mp, int bk, int a);
    mk = '0;
    mk.valid = 1'b1;
    mk.write = w[0];
    mk.cond_ok = ok[0];
    mk.mp_space = mp[0];
    mk.bank = bk[1:0];
    mk.addr = {20'h0, a[3:0]};
    mk.wdata = {8'h5A, 20'h0, a[3:0]};
  endfunction : mk

  initial begin : main
    {rst_n, reg_wr, reg_rd, slave_hit, reg_addr, reg_wdata, dma_req, ack_dly} = '0;
    {bus_master, bus_suspend_n} = 2'b11;
    req = '0;
    {n_errors, num_checks, er} = '0;
    cfg = 32'h1 << `EBAC_MP_WAIT_BIT;
    for (int b = 0; b < 4; b++) cfg |= (b | 32'hC) << `EBAC_WM_LSB(b);
    repeat (6) @(posedge clk);
    #1 chk("rd_n in reset", 1, rd_n);
    chk("addr_oe in reset", 0, addr_oe);
    chk("boot_select_n in reset", 1, boot_n);
    @(posedge clk) rst_n <= 1'b1;
    rreg(`EBAC_REG_WAIT, v);
    chk("wait reset", `EBAC_WAIT_RESET, v);
    rreg(4'hC, v);
    chk("unmapped read", 0, v);
    wreg(`EBAC_REG_WAIT, cfg);
    rreg(`EBAC_REG_WAIT, v);
    chk("wait config", cfg, v);
    $display("registers done");
    foreach (rt[i]) begin
      r = mk(rt[i][0], rt[i][1], rt[i][2], rt[i][3], rt[i][4]);
      @(posedge clk);
      req <= r;
      ack_dly <= 3'(rt[i][5]);
      wt(0, n);
      if (rt[i][6] >= 0) chk("cycles", 32'(2 + rt[i][6]), 32'(n));
      if (rt[i][1] && rt[i][0]) em[rt[i][4]] = r.wdata;
      if (rt[i][1] && !rt[i][0]) er = em[rt[i][4]];
      if (!rt[i][0]) chk("rdata", er, rdata);
    end
    $display("access table done");
    @(posedge clk);
    req <= mk(0, 1, 0, 0, 1);
    ack_dly <= 3'h3;
    wt(2, n);
    chk("rdata after abort", em[1], rdata);
    @(posedge clk);
    req <= '0;
    bus_suspend_n <= 1'b0;
    repeat (2) @(posedge clk);
    req <= mk(0, 1, 0, 3, 4);
    repeat (3) @(posedge clk);
    #1 chk("addr_oe stalled", 0, addr_oe);
    chk("req_done stalled", 0, req_done);
    rreg(`EBAC_REG_STATUS, v);
    chk("status stalled", 32'h7, v);
    @(posedge clk) bus_suspend_n <= 1'b1;
    wt(0, n);
    chk("rdata after stall", em[4], rdata);
    $display("suspend cases done");
    @(posedge clk);
    req <= '0;
    bus_master <= 1'b0;
    @(posedge clk) req <= mk(0, 1, 0, 2, 3);
    repeat (4) @(posedge clk);
    #1 chk("rd_n no master", 1, rd_n);
    chk("req_done no master", 0, req_done);
    @(posedge clk) bus_master <= 1'b1;
    wt(0, n);
    chk("rdata as master", em[3], rdata);
    @(posedge clk);
    req <= '0;
    slave_hit <= 1'b1;
    dma_req <= 2'b01;
    @(posedge clk) #1 chk("ack_o first", 0, ack_o);
    chk("ack_oe", 1, ack_oe);
    @(posedge clk) #1 chk("ack_o later", 1, ack_o);
    @(posedge clk) #1 chk("dma_grant_n", 2'b10, dma_grant_n);
    @(posedge clk);
    slave_hit <= 1'b0;
    dma_req <= 2'b00;
    repeat (2) @(posedge clk);
    rreg(`EBAC_REG_CAPT, v);
    chk("capture reg", em[3], v);
    $display("mastership, grant and slave cases done");
    close_out();
  end
endmodule : tb_top
